// ### hw/mpeh_pkg.sv
// package for the minimum, reverse-energy and hysteresis command bank
// assumes a byte-wide command code and a register port driven by a bus front end
`default_nettype none
package mpeh_pkg;
  // ==========================================================
  // command codes
  localparam logic [7:0]  CMD_LOW_CURR   = 8'he3;
  localparam logic [7:0]  CMD_LOW_PWR    = 8'he4;
  localparam logic [7:0]  CMD_REV_EXT    = 8'he5;
  localparam logic [7:0]  CMD_HYST_LO    = 8'hf2;
  localparam logic [7:0]  CMD_HYST_HI    = 8'hf3;
  // ==========================================================
  // reset values
  localparam logic [15:0] RST_LOW_CURR   = 16'h07ff;
  localparam logic [15:0] RST_LOW_PWR    = 16'h7fff;
  localparam logic [15:0] RST_HYST_LO    = 16'h8000;
  localparam logic [15:0] RST_HYST_HI    = 16'h7fff;
  localparam logic [23:0] RST_ENERGY     = 24'h000000;
  localparam logic [15:0] RST_WRAP       = 16'h0000;
  // wrap points: unsigned variant wraps from all ones, signed from max positive
  localparam logic [23:0] WRAP_FROM_U    = 24'hffffff;
  localparam logic [23:0] WRAP_FROM_S    = 24'h7fffff;
  localparam logic [23:0] WRAP_TO        = 24'h000000;
  // ==========================================================
  // extended read field positions
  localparam int          POS_COUNT      = 40;
  localparam int          POS_WRAP       = 24;
  localparam int          POS_ENERGY     = 0;

  // register write request
  typedef struct packed {
    logic        wr;
    logic [7:0]  cmd;
    logic [15:0] data;
  } mpeh_wr_t;

  // one sample update from the measurement path
  typedef struct packed {
    logic        cur_vld;
    logic [15:0] cur;
    logic        pwr_vld;
    logic [15:0] pwr;
    logic        eng_vld;
    logic [23:0] eng;
    logic [23:0] count;
  } mpeh_smp_t;
endpackage : mpeh_pkg
`default_nettype wire

// ### hw/mpeh_regs.sv
// lowest-value records, extended reverse-energy read and hysteretic comparator
// assumes a command front end presents one-cycle writes and reads a registered port one edge after the code
`default_nettype none
// ==========================================================
module mpeh_regs
  import mpeh_pkg::*;
#(
  parameter bit SIGNED_VARIANT = 1'b0             // 1: two's complement energy
) (
  input  wire logic        clk_i,                 // 100 MHz logic clock
  input  wire logic        sys_rst_i,             // synchronous reset, high
  input  wire mpeh_wr_t    wr_i,                  // register write request
  input  wire logic [7:0]  rd_cmd_i,              // command code to read
  output logic      [63:0] rd_data_o,             // read data, low 16 bits used except the extended read
  output logic             rd_hit_o,              // read code is mapped
  input  wire mpeh_smp_t   smp_i,                 // measurement samples
  input  wire logic [15:0] cmp_value_i,           // value under comparison
  input  wire logic        gpo_sel_i,             // route comparator to pin
  output logic             above_upper_flag_o,    // value over upper threshold
  output logic             below_lower_flag_o,    // value under lower threshold
  output logic             comparator_output_state_o, // hysteretic state
  output logic             general_output_pin_o   // general-purpose output
);

  // ==========================================================
  // storage
  logic        [15:0] low_cur_ff,  nxt_low_cur;
  logic        [15:0] low_pwr_ff,  nxt_low_pwr;
  logic        [15:0] hyst_lo_ff,  nxt_hyst_lo;
  logic        [15:0] hyst_hi_ff,  nxt_hyst_hi;
  logic        [23:0] energy_ff;
  logic        [23:0] count_ff;
  logic        [15:0] wrap_ff,     nxt_wrap;
  logic               above_ff,    below_ff;
  logic               state_ff,    nxt_state;
  logic               gpo_ff;

  // ==========================================================
  // write decode; records compare as signed direct-format values
  wire wr_cur  = wr_i.wr && (wr_i.cmd == CMD_LOW_CURR);
  wire wr_pwr  = wr_i.wr && (wr_i.cmd == CMD_LOW_PWR);
  wire wr_lo   = wr_i.wr && (wr_i.cmd == CMD_HYST_LO);
  wire wr_hi   = wr_i.wr && (wr_i.cmd == CMD_HYST_HI);
  wire cur_new = smp_i.cur_vld && ($signed(smp_i.cur) < $signed(low_cur_ff));
  wire pwr_new = smp_i.pwr_vld && ($signed(smp_i.pwr) < $signed(low_pwr_ff));

  // any write to a record restores default; zero is the host's clear
  // value, and a nonzero write has no defined meaning so it also clears
  // a sample in the write cycle is dropped: the clear is the host's intent
  assign nxt_low_cur = wr_cur ? RST_LOW_CURR
                     : cur_new ? smp_i.cur : low_cur_ff;
  assign nxt_low_pwr = wr_pwr ? RST_LOW_PWR
                     : pwr_new ? smp_i.pwr : low_pwr_ff;
  assign nxt_hyst_lo = wr_lo ? wr_i.data : hyst_lo_ff;
  assign nxt_hyst_hi = wr_hi ? wr_i.data : hyst_hi_ff;

  // ==========================================================
  // wrap detect: previous value at the variant's wrap point, new value zero
  wire [23:0] wrap_from = SIGNED_VARIANT ? WRAP_FROM_S : WRAP_FROM_U;
  wire        wrapped   = smp_i.eng_vld && (energy_ff == wrap_from)
                          && (smp_i.eng == WRAP_TO);
  assign nxt_wrap = wrapped ? 16'(wrap_ff + 16'h0001) : wrap_ff;

  // ==========================================================
  // comparator; thresholds and value are signed direct format
  wire gt_hi = $signed(cmp_value_i) > $signed(hyst_hi_ff);
  wire lt_lo = $signed(cmp_value_i) < $signed(hyst_lo_ff);
  assign nxt_state = gt_hi ? 1'b1 : (lt_lo ? 1'b0 : state_ff);

  // lowest current record; reset and host clear share one default
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      low_cur_ff <= RST_LOW_CURR;
    end else begin
      low_cur_ff <= nxt_low_cur;
    end
  end

  // lowest power record; kept apart so each clears on its own command
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      low_pwr_ff <= RST_LOW_PWR;
    end else begin
      low_pwr_ff <= nxt_low_pwr;
    end
  end

  // lower threshold; the host owns it after reset
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      hyst_lo_ff <= RST_HYST_LO;
    end else begin
      hyst_lo_ff <= nxt_hyst_lo;
    end
  end

  // upper threshold; no check that it sits above the lower one
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      hyst_hi_ff <= RST_HYST_HI;
    end else begin
      hyst_hi_ff <= nxt_hyst_hi;
    end
  end

  // energy snapshot and shared count, held between samples
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      energy_ff <= RST_ENERGY;
      count_ff  <= RST_ENERGY;
    end else if (smp_i.eng_vld) begin
      energy_ff <= smp_i.eng;
      count_ff  <= smp_i.count;
    end
  end

  // wrap counter; past 0xffff it rolls over, so the host must poll it
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      wrap_ff <= RST_WRAP;
    end else begin
      wrap_ff <= nxt_wrap;
    end
  end

  // comparator flags, registered so status and pin change on one edge
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      above_ff <= 1'b0;
      below_ff <= 1'b0;
    end else begin
      above_ff <= gt_hi;
      below_ff <= lt_lo;
    end
  end

  // hysteretic state and pin; the pin takes the next state, so it never
  // lags the state bit by a cycle and cannot glitch between edges
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_ff <= 1'b0;
      gpo_ff   <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      gpo_ff   <= gpo_sel_i & nxt_state;
    end
  end

  // ==========================================================
  // read mux; bit order puts energy byte 0 on the wire first
  // the energy bits pass through unchanged in both variants: the
  // accumulator already holds the variant's encoding
  wire [63:0] rev_ext = ({40'h0, energy_ff} << POS_ENERGY)
                      | ({48'h0, wrap_ff}   << POS_WRAP)
                      | ({40'h0, count_ff}  << POS_COUNT);
  wire hit_cur = rd_cmd_i == CMD_LOW_CURR;
  wire hit_pwr = rd_cmd_i == CMD_LOW_PWR;
  wire hit_rev = rd_cmd_i == CMD_REV_EXT;
  wire hit_lo  = rd_cmd_i == CMD_HYST_LO;
  wire hit_hi  = rd_cmd_i == CMD_HYST_HI;

  // unmapped codes read as zero with hit low
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rd_data_o <= 64'h0;
      rd_hit_o  <= 1'b0;
    end else begin
      rd_hit_o  <= hit_cur | hit_pwr | hit_rev | hit_lo | hit_hi;
      rd_data_o <= hit_cur ? {48'h0, low_cur_ff}
                 : hit_pwr ? {48'h0, low_pwr_ff}
                 : hit_rev ? rev_ext
                 : hit_lo  ? {48'h0, hyst_lo_ff}
                 : hit_hi  ? {48'h0, hyst_hi_ff} : 64'h0;
    end
  end

  assign above_upper_flag_o        = above_ff;
  assign below_lower_flag_o        = below_ff;
  assign comparator_output_state_o = state_ff;
  assign general_output_pin_o      = gpo_ff;

  // ==========================================================
  // checks
  // every check is off in reset; the first edge after release
  // compares against reset values only, so no false start
  AST_CUR_CLEAR: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    wr_cur |=> low_cur_ff == RST_LOW_CURR) else $error("current record not restored");
  AST_PWR_CLEAR: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    wr_pwr |=> low_pwr_ff == RST_LOW_PWR) else $error("power record not restored");
  AST_CUR_MIN: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (smp_i.cur_vld && !wr_cur) |=> $signed(low_cur_ff) <= $signed($past(smp_i.cur)))
    else $error("current record above sample");
  AST_PWR_MIN: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (smp_i.pwr_vld && !wr_pwr) |=> $signed(low_pwr_ff) <= $signed($past(smp_i.pwr)))
    else $error("power record above sample");
  AST_WRAP_INC: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    wrapped |=> wrap_ff == $past(wrap_ff) + 16'h0001) else $error("wrap not counted");
  AST_WRAP_HOLD: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !wrapped |=> $stable(wrap_ff)) else $error("wrap counter moved");
  AST_HYST_HI: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    gt_hi |=> state_ff && above_ff) else $error("state not high");
  AST_HYST_LO: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (lt_lo && !gt_hi) |=> !state_ff && below_ff) else $error("state not low");
  AST_HYST_HOLD: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (!gt_hi && !lt_lo) |=> $stable(state_ff)) else $error("state moved in band");
  AST_THR_WR: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    wr_lo |=> hyst_lo_ff == $past(wr_i.data)) else $error("lower threshold not stored");
  AST_REV_READ: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    hit_rev |=> rd_data_o[39:24] == $past(wrap_ff) && rd_data_o[23:0] == $past(energy_ff))
    else $error("extended read layout wrong");

  // records: take only lower samples, hold otherwise, read back in the low 16 bits
  AST_CUR_TAKE: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (cur_new && !wr_cur) |=> low_cur_ff == $past(smp_i.cur))
    else $error("current record missed a lower sample");
  AST_PWR_TAKE: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (pwr_new && !wr_pwr) |=> low_pwr_ff == $past(smp_i.pwr))
    else $error("power record missed a lower sample");
  AST_CUR_KEEP: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (!smp_i.cur_vld && !wr_cur) |=> $stable(low_cur_ff))
    else $error("current record moved without cause");
  AST_PWR_KEEP: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (!smp_i.pwr_vld && !wr_pwr) |=> $stable(low_pwr_ff))
    else $error("power record moved without cause");
  AST_CUR_DROP: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (wr_cur && smp_i.cur_vld) |=> low_cur_ff == RST_LOW_CURR)
    else $error("current sample beat the clear");
  AST_PWR_DROP: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (wr_pwr && smp_i.pwr_vld) |=> low_pwr_ff == RST_LOW_PWR)
    else $error("power sample beat the clear");
  AST_RD_CUR: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    hit_cur |=> rd_data_o == {48'h0, $past(low_cur_ff)} && rd_hit_o)
    else $error("current record read wrong");
  AST_RD_PWR: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    hit_pwr |=> rd_data_o == {48'h0, $past(low_pwr_ff)} && rd_hit_o)
    else $error("power record read wrong");

  // energy: snapshot and count move only with a sample; the read packs all three
  AST_ENERGY_TAKE: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    smp_i.eng_vld |=> energy_ff == $past(smp_i.eng))
    else $error("energy sample not taken");
  AST_COUNT_TAKE: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    smp_i.eng_vld |=> count_ff == $past(smp_i.count))
    else $error("sample count not taken");
  AST_ENERGY_KEEP: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !smp_i.eng_vld |=> $stable(energy_ff) && $stable(count_ff))
    else $error("energy moved without a sample");
  AST_WRAP_POINT: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (smp_i.eng_vld && energy_ff != wrap_from) |=> $stable(wrap_ff))
    else $error("wrap counted off the wrap point");
  AST_REV_COUNT: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    hit_rev |=> rd_data_o[63:40] == $past(count_ff))
    else $error("extended read count wrong");
  AST_REV_BYTES: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    hit_rev |=> rd_data_o[31:24] == $past(wrap_ff[7:0])
                && rd_data_o[39:32] == $past(wrap_ff[15:8]))
    else $error("wrap count bytes swapped");
  AST_REV_EBYTES: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    hit_rev |=> rd_data_o[7:0] == $past(energy_ff[7:0])
                && rd_data_o[23:16] == $past(energy_ff[23:16]))
    else $error("energy bytes swapped");

  // thresholds: written only by their own command, read back unchanged
  AST_THR_HI_WR: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    wr_hi |=> hyst_hi_ff == $past(wr_i.data))
    else $error("upper threshold not stored");
  AST_THR_KEEP: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (!wr_lo && !wr_hi) |=> $stable(hyst_lo_ff) && $stable(hyst_hi_ff))
    else $error("threshold moved without a write");
  AST_RD_LO: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    hit_lo |=> rd_data_o == {48'h0, $past(hyst_lo_ff)} && rd_hit_o)
    else $error("lower threshold read wrong");
  AST_RD_HI: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    hit_hi |=> rd_data_o == {48'h0, $past(hyst_hi_ff)} && rd_hit_o)
    else $error("upper threshold read wrong");

  // comparator: flags follow the strict compares, pin follows state and select
  AST_ABOVE_FLAG: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    1'b1 |=> above_ff == ($signed($past(cmp_value_i)) > $signed($past(hyst_hi_ff))))
    else $error("above flag wrong");
  AST_BELOW_FLAG: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    1'b1 |=> below_ff == ($signed($past(cmp_value_i)) < $signed($past(hyst_lo_ff))))
    else $error("below flag wrong");
  AST_PIN: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    1'b1 |=> general_output_pin_o == ($past(gpo_sel_i) && state_ff))
    else $error("output pin does not follow state");

  // covers: wrap, clear then new sample, rise, fall and a driven pin

  COV_WRAP:  cover property (@(posedge clk_i) disable iff (sys_rst_i) wrapped);
  COV_CLEAR: cover property (@(posedge clk_i) disable iff (sys_rst_i) wr_cur ##1 cur_new);
  COV_RISE:  cover property (@(posedge clk_i) disable iff (sys_rst_i) !state_ff ##1 state_ff);
  COV_FALL:  cover property (@(posedge clk_i) disable iff (sys_rst_i) state_ff ##1 !state_ff);
  COV_PIN:   cover property (@(posedge clk_i) disable iff (sys_rst_i) general_output_pin_o);

endmodule : mpeh_regs
`default_nettype wire

// ### verification/mpeh_host.sv
// host model: issues command writes and reads on the register port
// assumes tasks are entered right after a rising clock edge
`default_nettype none
module mpeh_host
  import mpeh_pkg::*;
(
  input  wire logic        clk_i,      // logic clock
  output var  mpeh_wr_t    wr_o,       // write request
  output var  logic [7:0]  rd_cmd_o,   // command to read
  input  wire logic [63:0] rd_data_i,  // read data
  input  wire logic        rd_hit_i    // read was mapped
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    wr_o     = '0;
    rd_cmd_o = 8'h00;
  end
  // ==========================================================
  // write: one-cycle pulse, then a spare edge so pulses never merge
  task automatic write_cmd(input logic [7:0] cmd, input logic [15:0] data);
    wr_o <= '{1'b1, cmd, data};
    @(posedge clk_i);
    wr_o <= '0;
    @(posedge clk_i);
  endtask : write_cmd
  // read: answer is registered, so take it one edge after the command
  task automatic read_cmd(input logic [7:0] cmd, output logic [63:0] d, output logic h);
    rd_cmd_o <= cmd;
    @(posedge clk_i);
    #1;
    d = rd_data_i;
    h = rd_hit_i;
    @(posedge clk_i);
  endtask : read_cmd
endmodule : mpeh_host
`default_nettype wire

// ### verification/tb_min_peak_energy_hyst_regs.sv
// bench for the minimum, reverse-energy and hysteresis command bank
// assumes the host model owns the register port and the bench owns samples
`default_nettype none
module tb_min_peak_energy_hyst_regs;
  import mpeh_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i, sys_rst_i, gpo_sel_i, above, below, state, pin, hit, h;
  logic [15:0] cmp_value_i;
  logic [63:0] rd_data, d, rd_data_s;
  logic [7:0]  rd_cmd;
  mpeh_wr_t    wr;
  mpeh_smp_t   smp;
  int          err_total = 0;
  int          tests_run = 0;
  logic [7:0]  cmds [6] = '{CMD_LOW_CURR, CMD_LOW_PWR, CMD_REV_EXT, CMD_HYST_LO, CMD_HYST_HI, 8'h00};
  logic [63:0] rvals [6] = '{64'h07ff, 64'h7fff, 64'h0, 64'h8000, 64'h7fff, 64'h0};
  mpeh_host mpeh_host_i (.clk_i(clk_i), .wr_o(wr), .rd_cmd_o(rd_cmd), .rd_data_i(rd_data),
                         .rd_hit_i(hit));
  mpeh_regs #(.SIGNED_VARIANT(1'b0)) mpeh_regs_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .wr_i(wr), .rd_cmd_i(rd_cmd), .rd_data_o(rd_data), .rd_hit_o(hit), .smp_i(smp),
    .cmp_value_i(cmp_value_i), .gpo_sel_i(gpo_sel_i), .above_upper_flag_o(above),
    .below_lower_flag_o(below), .comparator_output_state_o(state),
    .general_output_pin_o(pin));
  // signed variant shares all inputs; only its read data is checked
  mpeh_regs #(.SIGNED_VARIANT(1'b1)) mpeh_regs_s_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .wr_i(wr), .rd_cmd_i(rd_cmd), .rd_data_o(rd_data_s), .rd_hit_o(), .smp_i(smp),
    .cmp_value_i(cmp_value_i), .gpo_sel_i(gpo_sel_i), .above_upper_flag_o(),
    .below_lower_flag_o(), .comparator_output_state_o(), .general_output_pin_o());
  // ==========================================================
  // shared checking tasks
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic rd_chk(input string what, input logic [7:0] cmd, input logic [63:0] exp);
    mpeh_host_i.read_cmd(cmd, d, h);
    check(what, d, exp);
  endtask : rd_chk
  // sample pulse lasts one cycle; the idle cycle keeps pulses apart
  task automatic smp_go(input logic [2:0] v, input logic [15:0] c, input logic [15:0] p,
                        input logic [23:0] e, input logic [23:0] n);
    smp <= '{v[2], c, v[1], p, v[0], e, n};
    @(posedge clk_i);
    smp <= '0;
    @(posedge clk_i);
  endtask : smp_go
  // flags and state are registered: look one edge after the value lands
  task automatic cmp(input logic [15:0] v, input logic [3:0] exp);
    cmp_value_i <= v;
    @(posedge clk_i);
    #1;
    check("comparator", {60'h0, above, below, state, pin}, {60'h0, exp});
    @(posedge clk_i);
  endtask : cmp
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : report_and_stop
  // ==========================================================
  // clock and watchdog
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    repeat (3000) @(posedge clk_i);
    err_total++;
    report_and_stop();
  end
  // ==========================================================
  // tests
  initial begin
    sys_rst_i = 1'b1;
    gpo_sel_i = 1'b1;
    cmp_value_i = 16'h0000;
    smp = '0;
    repeat (4) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      rd_chk("reset value", cmds[i], rvals[i]);
      check("read hit", {63'h0, h}, {63'h0, (i < 5)});
    end
    $display("test reset done");
    smp_go(3'b100, 16'h8000, 16'h0, 24'h0, 24'h0);
    smp_go(3'b110, 16'h0100, 16'hffff, 24'h0, 24'h0);
    rd_chk("lowest current", CMD_LOW_CURR, 64'h8000);
    rd_chk("lowest power", CMD_LOW_PWR, 64'hffff);
    mpeh_host_i.write_cmd(CMD_LOW_CURR, 16'h0000);
    mpeh_host_i.write_cmd(CMD_LOW_PWR, 16'h0000);
    rd_chk("current cleared", CMD_LOW_CURR, 64'h07ff);
    rd_chk("power cleared", CMD_LOW_PWR, 64'h7fff);
    $display("test records done");
    smp_go(3'b001, 16'h0, 16'h0, 24'hffffff, 24'h000122);
    smp_go(3'b001, 16'h0, 16'h0, 24'h000000, 24'h000123);
    rd_chk("energy wrap", CMD_REV_EXT, {24'h000123, 16'h0001, 24'h0});
    check("wrap low byte", d[31:24], 64'h01);
    smp_go(3'b001, 16'h0, 16'h0, 24'h123456, 24'h000124);
    mpeh_host_i.write_cmd(CMD_REV_EXT, 16'hffff);
    rd_chk("energy", CMD_REV_EXT, {24'h000124, 16'h0001, 24'h123456});
    check("energy byte0", d[7:0], 64'h56);
    check("energy byte2", d[23:16], 64'h12);
    smp_go(3'b001, 16'h0, 16'h0, 24'h7fffff, 24'h000125);
    smp_go(3'b001, 16'h0, 16'h0, 24'h000000, 24'h000126);
    rd_chk("unsigned no wrap", CMD_REV_EXT, {24'h000126, 16'h0001, 24'h0});
    check("signed wrap", rd_data_s, {24'h000126, 16'h0001, 24'h0});
    $display("test energy done");
    mpeh_host_i.write_cmd(CMD_HYST_LO, 16'h0010);
    mpeh_host_i.write_cmd(CMD_HYST_HI, 16'h0100);
    rd_chk("lower threshold", CMD_HYST_LO, 64'h0010);
    rd_chk("upper threshold", CMD_HYST_HI, 64'h0100);
    cmp(16'h0200, 4'b1011);
    cmp(16'h0100, 4'b0011);
    cmp(16'h0010, 4'b0011);
    cmp(16'h000f, 4'b0100);
    cmp(16'h0050, 4'b0000);
    gpo_sel_i <= 1'b0;
    cmp(16'h0200, 4'b1010);
    $display("test comparator done");
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    rd_chk("threshold after reset", CMD_HYST_LO, 64'h8000);
    rd_chk("record after reset", CMD_LOW_CURR, 64'h07ff);
    cmp(16'h0200, 4'b0000);
    $display("test reset again done");
    report_and_stop();
  end
endmodule : tb_min_peak_energy_hyst_regs
`default_nettype wire
